// *** core/acs_pkg.sv ***
package acs_pkg;
  // Bus geometry
  localparam int ADDR_W = 12;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_LOOP_CTRL  = 8'h52;
  localparam logic [7:0] IDX_CLK_SRC    = 8'h53;
  localparam logic [7:0] IDX_OUT_PHASE  = 8'h64;
  localparam logic [7:0] IDX_DECIM_MODE = 8'h70;
  localparam logic [7:0] IDX_ROUTE_STAT = 8'h71;

  // Field positions
  localparam int LOOP_EN_BIT      = 0;
  localparam int DUTY_FIX_BIT     = 1;
  localparam int LOOP_OUT_CLK_BIT = 2;
  localparam int LOOP_RESET_BIT   = 3;
  localparam int LOOP_PHASE_LSB   = 4;
  localparam int CLK_SRC_BIT      = 0;
  localparam int DECIM_PHASE_LSB  = 0;
  localparam int PHASE_DLY_EN_BIT = 3;
  localparam int DECIM_EN_BIT     = 0;

  // Reset values and writable bits
  localparam logic [7:0] RST_LOOP_CTRL  = 8'h08;
  localparam logic [7:0] RST_CLK_SRC    = 8'h00;
  localparam logic [7:0] RST_OUT_PHASE  = 8'h00;
  localparam logic [7:0] RST_DECIM_MODE = 8'h00;
  localparam logic [7:0] MASK_LOOP_CTRL  = 8'h7f;
  localparam logic [7:0] MASK_CLK_SRC    = 8'h01;
  localparam logic [7:0] MASK_OUT_PHASE  = 8'h0f;
  localparam logic [7:0] MASK_DECIM_MODE = 8'h01;
  localparam logic [7:0] LOOP_RESET_MASK = 8'h08;

  typedef enum logic [1:0] {
    CORE_DIRECT = 2'b00,
    CORE_LOOP   = 2'b01,
    CORE_PLL    = 2'b11
  } acs_core_src_t;

  typedef enum logic [1:0] {
    OUT_INPUT_BUF = 2'b00,
    OUT_LOOP      = 2'b01,
    OUT_DECIM     = 2'b11,
    OUT_PLL       = 2'b10
  } acs_out_src_t;
endpackage

// *** core/acs_reg_byte.sv ***
`timescale 1ns/1ps
module acs_reg_byte #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK   = 8'hff
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // Write side
  input  wire logic       wrEn,
  input  wire logic [7:0] wrData,
  input  wire logic [7:0] hwClear,
  // Stored value
  output logic      [7:0] value
);
  logic [7:0] next_value;

  if (WR_MASK == 8'h00) begin : g_chk
    $error("acs_reg_byte: no writable bit");
  end

  always_comb begin
    next_value = value & ~hwClear;
    // Software write wins over a hardware clear in the same cycle
    if (wrEn) begin
      next_value = wrData & WR_MASK;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      value <= RESET_VAL;
    end else begin
      value <= next_value;
    end
  end
endmodule

// *** core/acs_route.sv ***
`timescale 1ns/1ps
module acs_route (
  // Configuration
  input  wire logic                  clkSource,
  input  wire logic                  loopEn,
  input  wire logic                  dutyFix,
  input  wire logic                  loopOutEn,
  input  wire logic                  loopReset,
  input  wire logic                  phaseDlyEn,
  input  wire logic                  decimEn,
  input  wire logic [2:0]            loopPhase,
  input  wire logic [2:0]            decimPhase,
  // Decoded routing
  output acs_pkg::acs_core_src_t     coreSel,
  output acs_pkg::acs_out_src_t      outSel,
  output logic                       loopIn,
  output logic                       pllRef,
  output logic                       dutyFall,
  output logic [2:0]                 phaseSel,
  output logic                       phaseApply
);
  import acs_pkg::*;

  always_comb begin
    loopIn = !clkSource;
    pllRef = clkSource;
    if (clkSource) begin
      coreSel = CORE_PLL;
    end else if (loopEn && !loopReset) begin
      coreSel = CORE_LOOP;
    end else begin
      coreSel = CORE_DIRECT;
    end
    // Only the falling edge is moved; never on the synthesised clock
    dutyFall = dutyFix && loopEn && !clkSource;
    if (decimEn) begin
      outSel = OUT_DECIM;
    end else if (clkSource) begin
      outSel = OUT_PLL;
    end else if (loopOutEn && loopEn) begin
      outSel = OUT_LOOP;
    end else begin
      outSel = OUT_INPUT_BUF;
    end
    phaseSel   = decimEn ? decimPhase : loopPhase;
    phaseApply = phaseDlyEn && (outSel != OUT_INPUT_BUF);
  end
endmodule

// *** core/acs_clock_select.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Power-up clocks core directly from input.
// - Source 0: input feeds loop and core.
// - Source 1: core from PLL, input references.
// - Loop enable bit switches loop on.
// - Duty fix moves falling edge only.
// - Duty fix needs loop, never PLL.
// - Otherwise output clock from input buffer.
// - Decimation: output rate/phase from decimator field.
// - Loop phase field sets output phase.
// - Phase delay enable gates phase control.
// - Bit selects loop clock for output.
// - Loop reset bit holds loop reset.
module acs_clock_select (
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst_b,
  // AXI4-Lite write address and data
  input  wire logic [acs_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  // AXI4-Lite write response
  output logic [1:0]                     bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  // AXI4-Lite read
  input  wire logic [acs_pkg::ADDR_W-1:0] araddr,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  // Soft reset command from the device controller
  input  wire logic                      softResetReq,
  // Clock routing controls
  output acs_pkg::acs_core_src_t         coreClkSel,
  output logic                           loopInFromInput,
  output logic                           pllRefFromInput,
  output logic                           loopEnable,
  output logic                           loopResetOut,
  output logic                           dutyFallAdjust,
  output acs_pkg::acs_out_src_t          outClkSrc,
  output logic [2:0]                     outPhaseSel,
  output logic                           outPhaseApply
);
  import acs_pkg::*;

  // Index decode reads bits 9:2 and tests bits above 9 for zero
  if (ADDR_W < 11) begin : g_chk
    $error("acs_clock_select: address too narrow for map");
  end

  function automatic logic [7:0] idxOf(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] w;
    w = a[ADDR_W-1:2];
    idxOf = (w > (ADDR_W-2)'(8'hff)) ? 8'h00 : w[7:0];
  endfunction

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    logic [7:0] i;
    i = idxOf(a);
    isMapped = (a[ADDR_W-1:10] == '0) && (a[1:0] == 2'b00) &&
               (i == IDX_LOOP_CTRL || i == IDX_CLK_SRC || i == IDX_OUT_PHASE ||
                i == IDX_DECIM_MODE || i == IDX_ROUTE_STAT);
  endfunction

  // Configuration registers
  logic [7:0] loopCtrl;
  logic [7:0] clkSrcReg;
  logic [7:0] outPhase;
  logic [7:0] decimMode;
  logic [7:0] routeStat;

  // Write channel state
  logic                awHeld;
  logic                wHeld;
  logic [ADDR_W-1:0]   awAddr;
  logic [7:0]          wByte;
  logic                wLane;
  logic                next_awHeld;
  logic                next_wHeld;
  logic [ADDR_W-1:0]   next_awAddr;
  logic [7:0]          next_wByte;
  logic                next_wLane;
  logic                next_bvalid;
  logic [1:0]          next_bresp;
  logic                wrCommit;
  logic [7:0]          wrIdx;

  // Read channel state
  logic                next_rvalid;
  logic [31:0]         next_rdata;
  logic [1:0]          next_rresp;

  assign awready  = !awHeld && !bvalid;
  assign wready   = !wHeld && !bvalid;
  assign arready  = !rvalid;
  assign wrCommit = awHeld && wHeld && !bvalid;
  assign wrIdx    = idxOf(awAddr);

  // Address and data are accepted in either order
  always_comb begin
    next_awHeld = awHeld;
    next_wHeld  = wHeld;
    next_awAddr = awAddr;
    next_wByte  = wByte;
    next_wLane  = wLane;
    next_bvalid = bvalid;
    next_bresp  = bresp;
    if (awvalid && awready) begin
      next_awHeld = 1'b1;
      next_awAddr = awaddr;
    end
    if (wvalid && wready) begin
      next_wHeld = 1'b1;
      next_wByte = wdata[7:0];
      next_wLane = wstrb[0];
    end
    if (wrCommit) begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = isMapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= '0;
      wByte  <= 8'h00;
      wLane  <= 1'b0;
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else begin
      awHeld <= next_awHeld;
      wHeld  <= next_wHeld;
      awAddr <= next_awAddr;
      wByte  <= next_wByte;
      wLane  <= next_wLane;
      bvalid <= next_bvalid;
      bresp  <= next_bresp;
    end
  end

  // Read data is latched when the address is taken
  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      case (idxOf(araddr))
        IDX_LOOP_CTRL:  next_rdata = {24'h000000, loopCtrl};
        IDX_CLK_SRC:    next_rdata = {24'h000000, clkSrcReg};
        IDX_OUT_PHASE:  next_rdata = {24'h000000, outPhase};
        IDX_DECIM_MODE: next_rdata = {24'h000000, decimMode};
        IDX_ROUTE_STAT: next_rdata = {24'h000000, routeStat};
        default:        next_rdata = 32'h00000000;
      endcase
      if (!isMapped(araddr)) begin
        next_rdata = 32'h00000000;
      end
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end
  end

  // Soft reset drops the loop reset bit only while the loop is on
  logic [7:0] loopClear;
  assign loopClear = (softResetReq && loopCtrl[LOOP_EN_BIT]) ? LOOP_RESET_MASK : 8'h00;

  acs_reg_byte #(.RESET_VAL(RST_LOOP_CTRL), .WR_MASK(MASK_LOOP_CTRL)) u_loop_ctrl (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .wrEn    (wrCommit && wLane && isMapped(awAddr) && wrIdx == IDX_LOOP_CTRL),
    .wrData  (wByte),
    .hwClear (loopClear),
    .value   (loopCtrl)
  );

  acs_reg_byte #(.RESET_VAL(RST_CLK_SRC), .WR_MASK(MASK_CLK_SRC)) u_clk_src (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .wrEn    (wrCommit && wLane && isMapped(awAddr) && wrIdx == IDX_CLK_SRC),
    .wrData  (wByte),
    .hwClear (8'h00),
    .value   (clkSrcReg)
  );

  acs_reg_byte #(.RESET_VAL(RST_OUT_PHASE), .WR_MASK(MASK_OUT_PHASE)) u_out_phase (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .wrEn    (wrCommit && wLane && isMapped(awAddr) && wrIdx == IDX_OUT_PHASE),
    .wrData  (wByte),
    .hwClear (8'h00),
    .value   (outPhase)
  );

  acs_reg_byte #(.RESET_VAL(RST_DECIM_MODE), .WR_MASK(MASK_DECIM_MODE)) u_decim (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .wrEn    (wrCommit && wLane && isMapped(awAddr) && wrIdx == IDX_DECIM_MODE),
    .wrData  (wByte),
    .hwClear (8'h00),
    .value   (decimMode)
  );

  acs_core_src_t nextCore;
  acs_out_src_t  nextOut;
  logic          nextLoopIn;
  logic          nextPllRef;
  logic          nextDuty;
  logic [2:0]    nextPhase;
  logic          nextApply;

  acs_route u_route (
    .clkSource  (clkSrcReg[CLK_SRC_BIT]),
    .loopEn     (loopCtrl[LOOP_EN_BIT]),
    .dutyFix    (loopCtrl[DUTY_FIX_BIT]),
    .loopOutEn  (loopCtrl[LOOP_OUT_CLK_BIT]),
    .loopReset  (loopCtrl[LOOP_RESET_BIT]),
    .phaseDlyEn (outPhase[PHASE_DLY_EN_BIT]),
    .decimEn    (decimMode[DECIM_EN_BIT]),
    .loopPhase  (loopCtrl[LOOP_PHASE_LSB +: 3]),
    .decimPhase (outPhase[DECIM_PHASE_LSB +: 3]),
    .coreSel    (nextCore),
    .outSel     (nextOut),
    .loopIn     (nextLoopIn),
    .pllRef     (nextPllRef),
    .dutyFall   (nextDuty),
    .phaseSel   (nextPhase),
    .phaseApply (nextApply)
  );

  // Registered so the analog muxes never see decode glitches
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      coreClkSel      <= CORE_DIRECT;
      loopInFromInput <= 1'b1;
      pllRefFromInput <= 1'b0;
      loopEnable      <= 1'b0;
      loopResetOut    <= 1'b1;
      dutyFallAdjust  <= 1'b0;
      outClkSrc       <= OUT_INPUT_BUF;
      outPhaseSel     <= 3'h0;
      outPhaseApply   <= 1'b0;
    end else begin
      coreClkSel      <= nextCore;
      loopInFromInput <= nextLoopIn;
      pllRefFromInput <= nextPllRef;
      loopEnable      <= loopCtrl[LOOP_EN_BIT];
      loopResetOut    <= loopCtrl[LOOP_RESET_BIT];
      dutyFallAdjust  <= nextDuty;
      outClkSrc       <= nextOut;
      outPhaseSel     <= nextPhase;
      outPhaseApply   <= nextApply;
    end
  end

  assign routeStat = {1'b0, loopEnable && !loopResetOut, outPhaseApply, dutyFallAdjust,
                      outClkSrc, coreClkSel};

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_src_write;
    wrCommit && wLane && wrIdx == IDX_CLK_SRC && isMapped(awAddr) && wByte[CLK_SRC_BIT];
  endsequence
  sequence s_pll_route;
    ##1 clkSrcReg[CLK_SRC_BIT] ##1 (coreClkSel == CORE_PLL) && pllRefFromInput;
  endsequence

  property p_direct_default;
    !clkSrcReg[CLK_SRC_BIT] && !(loopCtrl[LOOP_EN_BIT] && !loopCtrl[LOOP_RESET_BIT])
      |=> coreClkSel == CORE_DIRECT;
  endproperty
  a_direct_default: assert property (p_direct_default) else $error("core not direct");

  property p_loop_input;
    !clkSrcReg[CLK_SRC_BIT] |=> loopInFromInput && coreClkSel != CORE_PLL;
  endproperty
  a_loop_input: assert property (p_loop_input) else $error("input not to loop");

  property p_pll_select;
    s_src_write |-> s_pll_route;
  endproperty
  a_pll_select: assert property (p_pll_select) else $error("PLL not selected");

  property p_loop_enable;
    $rose(loopCtrl[LOOP_EN_BIT]) |=> loopEnable ##1 $stable(loopEnable);
  endproperty
  a_loop_enable: assert property (p_loop_enable) else $error("loop not enabled");

  property p_duty_on;
    loopCtrl[DUTY_FIX_BIT] && loopCtrl[LOOP_EN_BIT] && !clkSrcReg[CLK_SRC_BIT] |=> dutyFallAdjust;
  endproperty
  a_duty_on: assert property (p_duty_on) else $error("duty fix missing");

  property p_duty_gate;
    dutyFallAdjust |-> $past(loopCtrl[LOOP_EN_BIT]) && coreClkSel != CORE_PLL;
  endproperty
  a_duty_gate: assert property (p_duty_gate) else $error("duty fix misapplied");

  property p_input_buf;
    !decimMode[DECIM_EN_BIT] && !clkSrcReg[CLK_SRC_BIT] && !loopCtrl[LOOP_OUT_CLK_BIT]
      |=> outClkSrc == OUT_INPUT_BUF && !outPhaseApply;
  endproperty
  a_input_buf: assert property (p_input_buf) else $error("output clock not buffer");

  property p_decim_phase;
    decimMode[DECIM_EN_BIT] |=> outClkSrc == OUT_DECIM &&
      outPhaseSel == $past(outPhase[DECIM_PHASE_LSB +: 3]);
  endproperty
  a_decim_phase: assert property (p_decim_phase) else $error("decimation phase wrong");

  property p_loop_phase;
    !decimMode[DECIM_EN_BIT] |=> outPhaseSel == $past(loopCtrl[LOOP_PHASE_LSB +: 3]);
  endproperty
  a_loop_phase: assert property (p_loop_phase) else $error("loop phase wrong");

  property p_phase_gate;
    !outPhase[PHASE_DLY_EN_BIT] |=> !outPhaseApply;
  endproperty
  a_phase_gate: assert property (p_phase_gate) else $error("phase applied ungated");

  property p_loop_out;
    loopCtrl[LOOP_OUT_CLK_BIT] && loopCtrl[LOOP_EN_BIT] && !decimMode[DECIM_EN_BIT] &&
      !clkSrcReg[CLK_SRC_BIT] |=> outClkSrc == OUT_LOOP;
  endproperty
  a_loop_out: assert property (p_loop_out) else $error("loop clock not output");

  property p_loop_reset;
    loopCtrl[LOOP_RESET_BIT] |=> loopResetOut && coreClkSel != CORE_LOOP;
  endproperty
  a_loop_reset: assert property (p_loop_reset) else $error("loop reset not held");
endmodule

// *** tb/acs_clk_src_model.sv ***
`timescale 1ns/1ps
module acs_clk_src_model #(
  parameter int HALF_NS = 3
) (
  // Control from the bench
  input  wire logic present,
  input  wire logic slow,
  // Differential sampling clock
  output logic      clkP,
  output logic      clkN
);
  // Clean 50% duty clock; the bench sets duty fix only to check its routing
  initial begin
    clkP = 1'b0;
    forever begin
      if (present) begin
        #(slow ? 2 * HALF_NS : HALF_NS);
        clkP = ~clkP;
      end else begin
        // Removed source parks low, not at its last level
        #1;
        clkP = 1'b0;
      end
    end
  end
  assign clkN = ~clkP;
endmodule

// *** tb/acs_clock_select_bench.sv ***
`timescale 1ns/1ps
module acs_clock_select_bench;
  import acs_pkg::*;
  logic              clk_sys;
  logic              rst_b;
  logic [ADDR_W-1:0] awaddr;
  logic              awvalid;
  logic              awready;
  logic [31:0]       wdata;
  logic [3:0]        wstrb;
  logic              wvalid;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic              bready;
  logic [ADDR_W-1:0] araddr;
  logic              arvalid;
  logic              arready;
  logic [31:0]       rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              rready;
  logic              softResetReq;
  acs_core_src_t     coreClkSel;
  logic              loopInFromInput;
  logic              pllRefFromInput;
  logic              loopEnable;
  logic              loopResetOut;
  logic              dutyFallAdjust;
  acs_out_src_t      outClkSrc;
  logic [2:0]        outPhaseSel;
  logic              outPhaseApply;
  logic              srcPresent;
  logic              srcSlow;
  int                num_errors;
  int                total_checks;

  acs_clock_select dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .softResetReq(softResetReq),
    .coreClkSel(coreClkSel), .loopInFromInput(loopInFromInput), .pllRefFromInput(pllRefFromInput),
    .loopEnable(loopEnable), .loopResetOut(loopResetOut), .dutyFallAdjust(dutyFallAdjust),
    .outClkSrc(outClkSrc), .outPhaseSel(outPhaseSel), .outPhaseApply(outPhaseApply));

  acs_clk_src_model src_u (.present(srcPresent), .slow(srcSlow), .clkP(), .clkN());

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic timeout();
    num_errors++;
    $display("ERROR handshake expected 1 seen 0");
    test_done();
  endtask

  function automatic logic [ADDR_W-1:0] ba(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic [1:0] er);
    logic ah, wh, done;
    logic [1:0] r;
    done = 1'b0;
    r = 2'b00;
    @(posedge clk_sys);
    awaddr <= ba(i);
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge clk_sys);
      ah = awvalid && awready;
      wh = wvalid && wready;
      done = bvalid;
      r = bresp;
      @(posedge clk_sys);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (done) bready <= 1'b0;
    end
    if (!done) timeout();
    // Routing follows one edge after the register write, on the same edge as the response handshake
    @(negedge clk_sys);
    chk("bresp", 32'(er), 32'(r));
  endtask

  task automatic rd(input logic [7:0] i, input logic [31:0] ed, input logic [1:0] er);
    logic ah, done;
    logic [31:0] d;
    logic [1:0] r;
    done = 1'b0;
    d = '0;
    r = '0;
    @(posedge clk_sys);
    araddr <= ba(i);
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge clk_sys);
      ah = arvalid && arready;
      done = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_sys);
      if (ah) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
    end
    if (!done) timeout();
    chk("rdata", ed, d);
    chk("rresp", 32'(er), 32'(r));
  endtask

  // f = {loopIn, pllRef, loopEn, loopRst, dutyFall}
  task automatic route(input acs_core_src_t c, input logic [4:0] f, input acs_out_src_t o,
                       input logic [2:0] p, input logic a);
    chk("routing", {19'h0, c, f, o, p, a}, {19'h0, coreClkSel, loopInFromInput, pllRefFromInput,
        loopEnable, loopResetOut, dutyFallAdjust, outClkSrc, outPhaseSel, outPhaseApply});
  endtask

  initial begin
    {rst_b, awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready, softResetReq} = '0;
    wstrb = 4'hf;
    srcPresent = 1'b1;
    srcSlow = 1'b0;
    num_errors = 0;
    total_checks = 0;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(negedge clk_sys);
    route(CORE_DIRECT, 5'b10010, OUT_INPUT_BUF, 3'h0, 1'b0);
    rd(IDX_LOOP_CTRL, 32'h08, RESP_OKAY);
    rd(IDX_CLK_SRC, 32'h00, RESP_OKAY);
    rd(IDX_OUT_PHASE, 32'h00, RESP_OKAY);
    $display("test reset done");
    wr(IDX_LOOP_CTRL, 32'h01, RESP_OKAY);
    route(CORE_LOOP, 5'b10100, OUT_INPUT_BUF, 3'h0, 1'b0);
    wr(IDX_LOOP_CTRL, 32'h09, RESP_OKAY);
    route(CORE_DIRECT, 5'b10110, OUT_INPUT_BUF, 3'h0, 1'b0);
    wr(IDX_LOOP_CTRL, 32'h03, RESP_OKAY);
    route(CORE_LOOP, 5'b10101, OUT_INPUT_BUF, 3'h0, 1'b0);
    wr(IDX_CLK_SRC, 32'hffffffff, RESP_OKAY);
    route(CORE_PLL, 5'b01100, OUT_PLL, 3'h0, 1'b0);
    rd(IDX_CLK_SRC, 32'h01, RESP_OKAY);
    wr(IDX_CLK_SRC, 32'h00, RESP_OKAY);
    wr(IDX_LOOP_CTRL, 32'h02, RESP_OKAY);
    route(CORE_DIRECT, 5'b10000, OUT_INPUT_BUF, 3'h0, 1'b0);
    $display("test source done");
    wr(IDX_LOOP_CTRL, 32'h55, RESP_OKAY);
    route(CORE_LOOP, 5'b10100, OUT_LOOP, 3'h5, 1'b0);
    wr(IDX_OUT_PHASE, 32'h08, RESP_OKAY);
    route(CORE_LOOP, 5'b10100, OUT_LOOP, 3'h5, 1'b1);
    wr(IDX_LOOP_CTRL, 32'h51, RESP_OKAY);
    wr(IDX_OUT_PHASE, 32'h0b, RESP_OKAY);
    wr(IDX_DECIM_MODE, 32'h01, RESP_OKAY);
    route(CORE_LOOP, 5'b10100, OUT_DECIM, 3'h3, 1'b1);
    rd(IDX_DECIM_MODE, 32'h01, RESP_OKAY);
    // Status: loop running, phase applied, decimated output, core from loop
    rd(IDX_ROUTE_STAT, 32'h6d, RESP_OKAY);
    wr(IDX_ROUTE_STAT, 32'h00, RESP_OKAY);
    rd(IDX_ROUTE_STAT, 32'h6d, RESP_OKAY);
    wr(IDX_DECIM_MODE, 32'h00, RESP_OKAY);
    wr(IDX_OUT_PHASE, 32'h00, RESP_OKAY);
    wr(IDX_LOOP_CTRL, 32'h00, RESP_OKAY);
    route(CORE_DIRECT, 5'b10000, OUT_INPUT_BUF, 3'h0, 1'b0);
    $display("test output clock done");
    wr(8'h00, 32'h01, RESP_SLVERR);
    rd(8'h00, 32'h00, RESP_SLVERR);
    // Lane 0 strobe low: write answered but dropped
    @(posedge clk_sys);
    wstrb <= 4'he;
    wr(IDX_CLK_SRC, 32'h01, RESP_OKAY);
    @(posedge clk_sys);
    wstrb <= 4'hf;
    rd(IDX_CLK_SRC, 32'h00, RESP_OKAY);
    $display("test unmapped done");
    // Source removed, then returns slower: software resets the loop
    wr(IDX_LOOP_CTRL, 32'h01, RESP_OKAY);
    srcPresent <= 1'b0;
    wr(IDX_LOOP_CTRL, 32'h09, RESP_OKAY);
    route(CORE_DIRECT, 5'b10110, OUT_INPUT_BUF, 3'h0, 1'b0);
    srcPresent <= 1'b1;
    srcSlow <= 1'b1;
    @(posedge clk_sys);
    softResetReq <= 1'b1;
    @(posedge clk_sys);
    softResetReq <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    route(CORE_LOOP, 5'b10100, OUT_INPUT_BUF, 3'h0, 1'b0);
    rd(IDX_LOOP_CTRL, 32'h01, RESP_OKAY);
    $display("test loop reset done");
    test_done();
  end
endmodule
